// file: rtl/usr8_shift_reg.sv
// Eight-bit universal shift/storage register with shared parallel bus
//
// Function
// RL1: Eight edge-triggered flip-flops form one register with clear, shifts, load and hold.
// RL2: Every change of contents, clear included, happens only on the rising clock edge.
// RL3: A low clear input at a rising edge zeroes all bits whatever the mode selects say.
// RL4: With both selects high each edge copies every parallel bus line into its bit.
// RL5: Select low-bit only high shifts right: serial input to bit zero, bit n to n+1.
// RL6: Select high-bit only high shifts left: serial input to bit seven, bit n to n-1.
// RL7: With both selects low the contents stay unchanged.
// RL8: Each bit is driven onto its bus line through a three-state buffer when enabled.
// RL9: The same bus lines are sampled as load data in parallel load mode.
// RL10: Either active-low output enable high puts every bus line in high impedance.
// RL11: With the buffers off, clear, shift, hold and load still work as selected.
// RL12: Both selects high also release the bus so outside logic can drive load data.
// RL13: Bit zero and bit seven appear on dedicated serial outputs for cascading.
// RL14: The outside party drives valid load data whenever it selects parallel load.
// RL15: The serial outputs are always driven, untouched by enables or bus release.
`timescale 1ns/1ps
module usr8_shift_reg (
    input  wire logic                        clock,                 // 50 MHz clock
    input  wire logic                        srst,                  // Sync reset, high
    input  wire logic                        sync_clear_n,          // Sync clear, low
    input  wire logic                        mode_select_low,       // Mode select bit 0
    input  wire logic                        mode_select_high,      // Mode select bit 1
    input  wire logic                        right_shift_serial_in, // Into bit 0
    input  wire logic                        left_shift_serial_in,  // Into bit 7
    input  wire logic                        bus_drive_enable_a_n,  // Bus enable, low
    input  wire logic                        bus_drive_enable_b_n,  // Bus enable, low
    input  wire logic [usr8_pkg::DATA_W-1:0] parallel_bus_in,       // Bus level seen
    output logic      [usr8_pkg::DATA_W-1:0] parallel_bus_out,      // Bus drive value
    output logic      [usr8_pkg::DATA_W-1:0] parallel_bus_oe,       // Bus drive enable
    output logic                             first_bit_serial_out,  // Bit 0
    output logic                             last_bit_serial_out,   // Bit 7
    input  wire logic                        psel,                  // APB select
    input  wire logic                        penable,               // APB enable
    input  wire logic                        pwrite,                // APB write
    input  wire logic [usr8_pkg::APB_AW-1:0] paddr,                 // APB address
    input  wire logic [usr8_pkg::APB_DW-1:0] pwdata,                // APB write data
    output logic      [usr8_pkg::APB_DW-1:0] prdata,                // APB read data
    output logic                             pready,                // APB ready
    output logic                             pslverr                // APB error
);
    import usr8_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [DATA_W-1:0] shift_q;
    logic [DATA_W-1:0] shift_d;
    logic [1:0]        mode;
    logic              bus_on;
    logic              release_q;
    logic              drop_q;
    logic [APB_DW-1:0] prdata_q;
    logic [APB_DW-1:0] rd_word;
    logic              setup;
    logic              wr_stb;
    logic              rd_stb;
    logic              hit_ctrl;
    logic              hit_status;
    logic              hit_snap;
    logic              hit_data;
    logic              snap_valid;
    logic              snap_ready;
    logic              head_valid;
    logic [DATA_W-1:0] head_data;
    logic              pop_head;

    assign mode = {mode_select_high, mode_select_low};

    // ------------------------------------------------------------
    // Next contents
    // ------------------------------------------------------------
    // Clear outranks every mode; enables play no part here
    always_comb begin
        shift_d = shift_q;
        if (!sync_clear_n) begin
            shift_d = SHIFT_RESET; // RL3
        end else begin
            case (mode)
                MODE_LOAD: begin
                    shift_d = parallel_bus_in; // RL4 RL9 RL14
                end
                MODE_RIGHT: begin
                    shift_d = {shift_q[DATA_W-2:0], right_shift_serial_in}; // RL5
                end
                MODE_LEFT: begin
                    shift_d = {left_shift_serial_in, shift_q[DATA_W-1:1]}; // RL6
                end
                default: begin
                    shift_d = shift_q; // RL7
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Storage flip-flops
    // ------------------------------------------------------------
    // Only the rising edge updates; the bus buffers never gate this
    always_ff @(posedge clock) begin
        if (srst) begin
            shift_q <= SHIFT_RESET;
        end else begin
            shift_q <= shift_d; // RL1 RL2 RL11
        end
    end

    // ------------------------------------------------------------
    // Parallel bus drivers
    // ------------------------------------------------------------
    // Load mode releases the bus even with both enables low, so a
    // careless enable setting cannot fight the outside load data
    assign bus_on = !bus_drive_enable_a_n && !bus_drive_enable_b_n  // RL10
                    && (mode != MODE_LOAD)                          // RL12
                    && !release_q;

    // Drive value straight from the flip-flops
    assign parallel_bus_out = shift_q; // RL8

    // One enable per line
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_bus_oe
            assign parallel_bus_oe[gi] = bus_on; // RL8
        end
    endgenerate

    // ------------------------------------------------------------
    // Serial outputs
    // ------------------------------------------------------------
    // Wired from the flops with no enable term at all
    assign first_bit_serial_out = shift_q[0];        // RL13 RL15
    assign last_bit_serial_out  = shift_q[DATA_W-1]; // RL13 RL15

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    usr8_apb_slave u_apb (
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pready     (pready),
        .pslverr    (pslverr),
        .setup      (setup),
        .wr_stb     (wr_stb),
        .rd_stb     (rd_stb),
        .hit_ctrl   (hit_ctrl),
        .hit_status (hit_status),
        .hit_snap   (hit_snap),
        .hit_data   (hit_data)
    );

    // Software bus release, an extra gate on top of the pins
    always_ff @(posedge clock) begin
        if (srst) begin
            release_q <= CTRL_RESET;
        end else if (wr_stb && hit_ctrl) begin
            release_q <= pwdata[CTRL_RELEASE_BIT];
        end
    end

    // Snapshot request refused while full; the drop flag records it.
    // A new drop in the clearing cycle wins over the clear.
    always_ff @(posedge clock) begin
        if (srst) begin
            drop_q <= 1'b0;
        end else if (wr_stb && hit_snap && !snap_ready) begin
            drop_q <= 1'b1;
        end else if (wr_stb && hit_status && pwdata[STAT_DROP_BIT]) begin
            drop_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Snapshot buffer
    // ------------------------------------------------------------
    assign snap_valid = wr_stb && hit_snap;
    assign pop_head   = rd_stb && hit_data;

    usr8_fifo2 u_fifo (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (snap_valid),
        .in_ready  (snap_ready),
        .in_data   (shift_q),
        .out_valid (head_valid),
        .out_ready (pop_head),
        .out_data  (head_data)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Assembled in setup so the access phase answers from a flop
    always_comb begin
        rd_word = '0;
        if (hit_ctrl) begin
            rd_word[CTRL_RELEASE_BIT] = release_q;
        end else if (hit_status) begin
            rd_word[DATA_W-1:0]             = shift_q;
            rd_word[STAT_FULL_BIT]          = !snap_ready;
            rd_word[STAT_EMPTY_BIT]         = !head_valid;
            rd_word[STAT_DROP_BIT]          = drop_q;
            rd_word[STAT_MODE_LSB+1:STAT_MODE_LSB] = mode;
        end else if (hit_data) begin
            rd_word[DATA_W-1:0]     = head_valid ? head_data : SHIFT_RESET;
            rd_word[DATA_VALID_BIT] = head_valid;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_q <= '0;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_word;
        end
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    a_clear_zeroes: assert property ( // RL3
        !sync_clear_n |=> (shift_q == SHIFT_RESET))
        else $error("clear did not zero the register");

    a_load_copies: assert property ( // RL4
        (sync_clear_n && mode == MODE_LOAD) |=> (shift_q == $past(parallel_bus_in)))
        else $error("parallel load did not copy the bus");

    a_right_shift: assert property ( // RL5
        (sync_clear_n && mode == MODE_RIGHT)
        |=> (shift_q == {$past(shift_q[6:0]), $past(right_shift_serial_in)}))
        else $error("right shift moved bits wrongly");

    a_left_shift: assert property ( // RL6
        (sync_clear_n && mode == MODE_LEFT)
        |=> (shift_q == {$past(left_shift_serial_in), $past(shift_q[7:1])}))
        else $error("left shift moved bits wrongly");

    a_hold_keeps: assert property ( // RL7
        (sync_clear_n && mode == MODE_HOLD) |=> $stable(shift_q))
        else $error("hold mode changed the register");

    a_enable_off: assert property ( // RL10
        (bus_drive_enable_a_n || bus_drive_enable_b_n) |-> (parallel_bus_oe == 8'h00))
        else $error("bus driven with an enable high");

    a_load_release: assert property ( // RL12
        (mode == MODE_LOAD) |-> (parallel_bus_oe == 8'h00))
        else $error("bus driven during parallel load");

    a_drive_on: assert property ( // RL8
        (!bus_drive_enable_a_n && !bus_drive_enable_b_n && mode != MODE_LOAD
         && !release_q) |-> (parallel_bus_oe == 8'hff && parallel_bus_out == shift_q))
        else $error("bus not driven with register contents");

    a_off_still_shifts: assert property ( // RL11
        ((bus_drive_enable_a_n || bus_drive_enable_b_n || release_q)
         && sync_clear_n && mode == MODE_RIGHT)
        |=> (last_bit_serial_out == $past(shift_q[6])))
        else $error("shifting stalled while the bus was off");

    a_serial_follow: assert property ( // RL13 RL15
        (sync_clear_n && mode == MODE_LOAD)
        |=> (first_bit_serial_out == $past(parallel_bus_in[0])
             && last_bit_serial_out == $past(parallel_bus_in[7])))
        else $error("serial outputs do not follow end bits");

    a_edge_only: assert property ( // RL2
        !$past(srst) |-> (shift_q == $past(shift_d)))
        else $error("register changed off the rising edge");

    a_full_refuses: assert property (
        (wr_stb && hit_snap && !snap_ready) |=> drop_q)
        else $error("refused snapshot not flagged");

    a_drop_clears: assert property (
        (wr_stb && hit_status && pwdata[STAT_DROP_BIT])
        |=> !drop_q)
        else $error("drop flag not cleared");

    a_release_wr: assert property (
        (wr_stb && hit_ctrl)
        |=> (release_q == $past(pwdata[CTRL_RELEASE_BIT])))
        else $error("release bit not written");

    a_release_off: assert property (
        release_q |-> (parallel_bus_oe == 8'h00))
        else $error("bus driven while released");

    a_unmapped_err: assert property (
        (psel && penable && !(hit_ctrl || hit_status || hit_snap || hit_data))
        |-> pslverr)
        else $error("unmapped access not flagged");

    a_prdata_holds: assert property (
        !(setup && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read");

    a_serial_bus_off: assert property ( // RL15
        ((bus_drive_enable_a_n || bus_drive_enable_b_n) && sync_clear_n
         && mode == MODE_RIGHT) |=> (first_bit_serial_out == $past(right_shift_serial_in)))
        else $error("serial output stalled with bus off");

    a_snap_lands: assert property (
        (wr_stb && hit_snap && snap_ready)
        |=> head_valid)
        else $error("snapshot not stored");

    a_empty_read: assert property (
        (setup && !pwrite && hit_data && !head_valid)
        |=> (prdata == '0))
        else $error("empty data read not zero");

    a_status_mode: assert property (
        (setup && !pwrite && hit_status)
        |=> (prdata[STAT_MODE_LSB+1:STAT_MODE_LSB] == $past(mode)))
        else $error("status mode field wrong");

    // ------------------------------------------------------------
    // Coverage of main scenarios
    // ------------------------------------------------------------
    c_load_then_right: cover property (
        (sync_clear_n && mode == MODE_LOAD) ##1 (sync_clear_n && mode == MODE_RIGHT));

    c_left_bus_off: cover property (
        sync_clear_n && mode == MODE_LEFT && bus_drive_enable_b_n);

    c_clear_in_load: cover property (!sync_clear_n && mode == MODE_LOAD);

    c_fifo_full_read: cover property (!snap_ready ##[1:20] pop_head);

endmodule : usr8_shift_reg

// file: rtl/usr8_pkg.sv
// Constants shared by the universal shift register block
package usr8_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned APB_AW   = 12;
    localparam int unsigned APB_DW   = 32;
    localparam int unsigned FIFO_DEP = 2;

    // ------------------------------------------------------------
    // Mode select codes, {mode_select_high, mode_select_low}
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_HOLD  = 2'h0;
    localparam logic [1:0] MODE_RIGHT = 2'h1;
    localparam logic [1:0] MODE_LEFT  = 2'h2;
    localparam logic [1:0] MODE_LOAD  = 2'h3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h000;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] OFS_SNAP   = 12'h008;
    localparam logic [APB_AW-1:0] OFS_DATA   = 12'h00c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RELEASE_BIT = 0;
    localparam int unsigned STAT_FULL_BIT    = 8;
    localparam int unsigned STAT_EMPTY_BIT   = 9;
    localparam int unsigned STAT_DROP_BIT    = 10;
    localparam int unsigned STAT_MODE_LSB    = 12;
    localparam int unsigned DATA_VALID_BIT   = 8;
    localparam logic [DATA_W-1:0] SHIFT_RESET = 8'h00;
    localparam logic              CTRL_RESET  = 1'h0;

endpackage : usr8_pkg

// file: rtl/usr8_fifo2.sv
// Two-entry valid/ready buffer for register snapshots
`timescale 1ns/1ps
module usr8_fifo2 (
    input  wire logic                      clock,     // System clock
    input  wire logic                      srst,      // Sync reset, high
    input  wire logic                      in_valid,  // Word offered
    output logic                           in_ready,  // Room for a word
    input  wire logic [usr8_pkg::DATA_W-1:0] in_data, // Word in
    output logic                           out_valid, // Word available
    input  wire logic                      out_ready, // Drain takes word
    output logic [usr8_pkg::DATA_W-1:0]    out_data   // Head word
);
    import usr8_pkg::*;

    logic [DATA_W-1:0] mem_q [FIFO_DEP];
    logic              wr_ptr_q;
    logic              rd_ptr_q;
    logic [1:0]        count_q;
    logic              push;
    logic              pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q];

    // Storage needs no reset, the count guards it
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end

endmodule : usr8_fifo2

// file: rtl/usr8_apb_slave.sv
// APB handshake and address decode for the shift register block
`timescale 1ns/1ps
module usr8_apb_slave (
    input  wire logic                        psel,     // APB select
    input  wire logic                        penable,  // APB access phase
    input  wire logic                        pwrite,   // APB direction
    input  wire logic [usr8_pkg::APB_AW-1:0] paddr,    // APB byte address
    output logic                             pready,   // Always ready
    output logic                             pslverr,  // Unmapped access
    output logic                             setup,    // Setup phase
    output logic                             wr_stb,   // Write takes effect
    output logic                             rd_stb,   // Read completes
    output logic                             hit_ctrl,   // Control selected
    output logic                             hit_status, // Status selected
    output logic                             hit_snap,   // Snapshot selected
    output logic                             hit_data    // Data selected
);
    import usr8_pkg::*;

    logic access;
    logic mapped;

    // Decode, first match wins
    always_comb begin
        hit_ctrl   = 1'b0;
        hit_status = 1'b0;
        hit_snap   = 1'b0;
        hit_data   = 1'b0;
        if (paddr == OFS_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == OFS_STATUS) begin
            hit_status = 1'b1;
        end else if (paddr == OFS_SNAP) begin
            hit_snap = 1'b1;
        end else if (paddr == OFS_DATA) begin
            hit_data = 1'b1;
        end
    end

    // Zero wait states: read data is prepared during setup
    assign mapped  = hit_ctrl || hit_status || hit_snap || hit_data;
    assign access  = psel && penable;
    assign setup   = psel && !penable;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign wr_stb  = access && pwrite && mapped;
    assign rd_stb  = access && !pwrite && mapped;

endmodule : usr8_apb_slave

// file: bench/usr8_bus_partner.sv
// Far-side bus logic: offers load data and resolves the shared parallel bus
`timescale 1ns/1ps
module usr8_bus_partner (
    input  wire logic                        clock,     // System clock
    input  wire logic [usr8_pkg::DATA_W-1:0] dev_out,   // Device drive value
    input  wire logic [usr8_pkg::DATA_W-1:0] dev_oe,    // Device drive enable
    input  wire logic [usr8_pkg::DATA_W-1:0] drv_data,  // Load data offered
    input  wire logic                        drv_en,    // Partner drives bus
    output logic      [usr8_pkg::DATA_W-1:0] bus_level  // Resolved wire level
);
    import usr8_pkg::*;

    logic [DATA_W-1:0] last_q;

    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    // No pull on these lines: an undriven line shows the inverse of its last
    // level, so stale data never passes for a fresh load word
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            case ({dev_oe[i], drv_en})
                2'h2:    bus_level[i] = dev_out[i];
                2'h1:    bus_level[i] = drv_data[i];
                2'h3:    bus_level[i] = 1'bx;        // Contention
                default: bus_level[i] = ~last_q[i];
            endcase
        end
    end

    // Last level seen, feeds the idle pattern
    always_ff @(posedge clock) begin
        last_q <= bus_level;
    end
endmodule : usr8_bus_partner

// file: bench/universal_shift_register8_test.sv
// Self-checking bench for the universal shift register block
`timescale 1ns/1ps
module universal_shift_register8_test;
    import usr8_pkg::*;

    logic              clock, srst, sync_clear_n, psel, penable, pwrite, pready, pslverr;
    logic              mode_select_low, mode_select_high, right_shift_serial_in;
    logic              left_shift_serial_in, bus_drive_enable_a_n, bus_drive_enable_b_n;
    logic              first_bit_serial_out, last_bit_serial_out, drv_en, rel, err;
    logic [DATA_W-1:0] bus_level, parallel_bus_out, parallel_bus_oe, drv_data, model, snap0;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rd;
    int                fail_count, tests_run;

    usr8_shift_reg usr8_shift_reg_inst (
        .clock, .srst, .sync_clear_n, .mode_select_low, .mode_select_high,
        .right_shift_serial_in, .left_shift_serial_in, .bus_drive_enable_a_n,
        .bus_drive_enable_b_n, .parallel_bus_in(bus_level), .parallel_bus_out,
        .parallel_bus_oe, .first_bit_serial_out, .last_bit_serial_out, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
    );
    usr8_bus_partner usr8_bus_partner_inst (
        .clock, .dev_out(parallel_bus_out), .dev_oe(parallel_bus_oe), .drv_data,
        .drv_en, .bus_level
    );

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : check

    function automatic logic [7:0] exp_oe(input logic [1:0] m);
        return (!bus_drive_enable_a_n && !bus_drive_enable_b_n && m != MODE_LOAD && !rel)
            ? 8'hff : 8'h00;
    endfunction : exp_oe

    // One operation per call; pins drop back to hold at the acting edge so no
    // operation is repeated by the next call
    task automatic step(input logic [1:0] m, input logic cn, input logic rs,
                        input logic ls, input logic [7:0] d);
        logic [7:0] nxt;
        nxt = !cn ? 8'h00 : m == MODE_LOAD ? d : m == MODE_RIGHT ? {model[6:0], rs}
            : m == MODE_LEFT ? {ls, model[7:1]} : model;
        @(posedge clock);
        {mode_select_high, mode_select_low} <= m;
        sync_clear_n <= cn;
        right_shift_serial_in <= rs;
        left_shift_serial_in <= ls;
        drv_data <= d;
        drv_en <= (m == MODE_LOAD);
        @(negedge clock);
        check(parallel_bus_out, model);
        check(parallel_bus_oe, exp_oe(m));
        @(posedge clock);
        {mode_select_high, mode_select_low} <= MODE_HOLD;
        sync_clear_n <= 1'b1;
        drv_en <= 1'b0;
        model = nxt;
        @(negedge clock);
        check(parallel_bus_out, model);
        check({last_bit_serial_out, first_bit_serial_out}, {model[7], model[0]});
        if (exp_oe(MODE_HOLD) == 8'hff) check(bus_level, model);
    endtask : step

    // APB transfer; waits for pready, takes read data and error at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {fail_count, tests_run, rel, drv_en, drv_data, model} = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {mode_select_high, mode_select_low, right_shift_serial_in} = '0;
        {left_shift_serial_in, bus_drive_enable_a_n, bus_drive_enable_b_n} = '0;
        srst = 1'b1;
        sync_clear_n = 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        check(parallel_bus_out, 8'h00);
        step(MODE_LOAD, 1, 0, 0, 8'ha5);
        for (int i = 0; i < 8; i++) step(MODE_RIGHT, 1, i[0], 0, 8'h00);
        for (int i = 0; i < 8; i++) step(MODE_LEFT, 1, 0, ~i[0], 8'h00);
        step(MODE_HOLD, 1, 1, 1, 8'h00);
        $display("Mode test done");
        for (int m = 0; m < 4; m++) begin
            step(MODE_LOAD, 1, 0, 0, 8'h3c);
            step(m[1:0], 0, 1, 1, 8'hff);
        end
        $display("Clear test done");
        for (int e = 3; e >= 0; e--) begin
            @(posedge clock);
            {bus_drive_enable_a_n, bus_drive_enable_b_n} <= e[1:0];
            step(MODE_LOAD, 1, 0, 0, 8'h96);
            step(MODE_RIGHT, 1, 1, 0, 8'h00);
            step(MODE_HOLD, 0, 0, 1, 8'h00);
        end
        $display("Enable test done");
        step(MODE_LOAD, 1, 0, 0, 8'h5a);
        apb(1, OFS_CTRL, 32'h1);
        rel = 1'b1;
        step(MODE_RIGHT, 1, 1, 0, 8'h00);
        apb(0, OFS_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1, OFS_CTRL, 32'h0);
        rel = 1'b0;
        apb(1, OFS_SNAP, 32'h0);
        snap0 = model;
        step(MODE_LEFT, 1, 0, 1, 8'h00);
        apb(1, OFS_SNAP, 32'h0);
        apb(1, OFS_SNAP, 32'h0);
        apb(0, OFS_STATUS, 32'h0);
        check(rd, (32'h1 << STAT_FULL_BIT) | (32'h1 << STAT_DROP_BIT) | 32'(model));
        apb(1, OFS_STATUS, 32'h1 << STAT_DROP_BIT);
        apb(0, OFS_DATA, 32'h0);
        check(rd, (32'h1 << DATA_VALID_BIT) | 32'(snap0));
        apb(0, OFS_DATA, 32'h0);
        check(rd, (32'h1 << DATA_VALID_BIT) | 32'(model));
        apb(0, OFS_DATA, 32'h0);
        check(rd, 32'h0);
        apb(0, OFS_STATUS, 32'h0);
        check(rd, (32'h1 << STAT_EMPTY_BIT) | 32'(model));
        apb(0, 12'h010, 32'h0);
        check(rd, 32'h0);
        check(32'(err), 32'h1);
        $display("Register test done");
        give_verdict();
    end
endmodule : universal_shift_register8_test
